// ==== hdl/port_cfg_pkg.sv ====
/*
 Constants for the general-purpose port configuration registers of
 ports one to four: register addresses, reset values and pin counts.
 Assumes an 8-bit special function register bus with 8-bit addresses.
*/
package port_cfg_pkg;
   // Register addresses on the special function register bus.
   localparam logic [7:0] ADDR_P2_LATCH = 8'hA0;
   localparam logic [7:0] ADDR_P2_OUT_MODE = 8'hA6;
   localparam logic [7:0] ADDR_P3_OUT_MODE = 8'hA7;
   localparam logic [7:0] ADDR_P4_OUT_MODE = 8'hAE;
   localparam logic [7:0] ADDR_P3_LATCH = 8'hB0;
   localparam logic [7:0] ADDR_P4_LATCH = 8'hC7;
   localparam logic [7:0] ADDR_P1_SKIP = 8'hD5;
   localparam logic [7:0] ADDR_P2_SKIP = 8'hD6;
   localparam logic [7:0] ADDR_P3_SKIP = 8'hDF;
   localparam logic [7:0] ADDR_P2_IN_MODE = 8'hF3;
   localparam logic [7:0] ADDR_P3_IN_MODE = 8'hF4;
   localparam logic [7:0] ADDR_P4_IN_MODE = 8'hF5;
   // Bit addresses of latch bits: base plus bit index in low 3 bits.
   localparam logic [4:0] BIT_BASE_P2 = 5'h14;
   localparam logic [4:0] BIT_BASE_P3 = 5'h16;
   // Reset values.
   localparam logic [7:0] RST_LATCH = 8'hFF;
   localparam logic [7:0] RST_IN_MODE = 8'hFF;
   localparam logic [7:0] RST_OUT_MODE = 8'h00;
   localparam logic [7:0] RST_SKIP = 8'h00;
   // Pin presence masks per package size.
   localparam logic [7:0] PINS_ALL = 8'hFF;
   localparam logic [7:0] PINS_P3_SMALL = 8'h01;
   localparam logic [7:0] PINS_NONE = 8'h00;
   localparam logic [7:0] READ_NONE = 8'h00;
endpackage

// ==== hdl/port_pin_config_regs.sv ====
/*
 Port configuration and data registers for ports one to four.
 Holds latch, input mode, output mode and skip registers, drives the
 pads and answers latch reads with sampled pin levels.
 Assumes a single-cycle special function register bus from the core;
 paging is ignored since every register here sits on all pages.
*/
`timescale 1ns/1ps
module port_pin_config_regs (
   input wire logic clk_in, // System clock, 200 MHz.
   input wire logic rst_b_in, // Synchronous reset, active low.
   input wire logic large_pkg_in, // One for the 48-pin package.
   input wire logic sfr_wr_in, // Byte write strobe.
   input wire logic sfr_rd_in, // Byte read strobe.
   input wire logic [7:0] sfr_addr_in, // Register address.
   input wire logic [7:0] sfr_wdata_in, // Write data.
   input wire logic bit_wr_in, // Single-bit write strobe.
   input wire logic bit_rd_in, // Single-bit read strobe.
   input wire logic [7:0] bit_addr_in, // Bit address.
   input wire logic bit_wdata_in, // Bit write value.
   input wire logic [7:0] p2_pin_in, // Port two pin levels.
   input wire logic [7:0] p3_pin_in, // Port three pin levels.
   input wire logic [7:0] p4_pin_in, // Port four pin levels.
   output logic [7:0] sfr_rdata_out, // Read data.
   output logic sfr_hit_out, // Read address was decoded.
   output logic bit_rdata_out, // Single-bit read data.
   output logic [7:0] p2_pin_out, // Port two drive level.
   output logic [7:0] p2_pin_oe_out, // Port two drive enable.
   output logic [7:0] p2_pullup_out, // Port two pull-up enable.
   output logic [7:0] p3_pin_out, // Port three drive level.
   output logic [7:0] p3_pin_oe_out, // Port three drive enable.
   output logic [7:0] p3_pullup_out, // Port three pull-up enable.
   output logic [7:0] p4_pin_out, // Port four drive level.
   output logic [7:0] p4_pin_oe_out, // Port four drive enable.
   output logic [7:0] p4_pullup_out, // Port four pull-up enable.
   output logic [7:0] p1_skip_out, // Port one crossbar skip.
   output logic [7:0] p2_skip_out, // Port two crossbar skip.
   output logic [7:0] p3_skip_out // Port three crossbar skip.
);
   logic [7:0] port_two_pin_latch; // Port two output latch.
   logic [7:0] port_three_pin_latch; // Port three output latch.
   logic [7:0] port_four_pin_latch; // Port four output latch.
   logic [7:0] port_two_input_mode; // Port two analog or digital.
   logic [7:0] port_three_input_mode; // Port three analog or digital.
   logic [7:0] port_four_input_mode; // Port four analog or digital.
   logic [7:0] port_two_output_mode; // Port two driver type.
   logic [7:0] port_three_output_mode; // Port three driver type.
   logic [7:0] port_four_output_mode; // Port four driver type.
   logic [7:0] port_one_crossbar_skip; // Port one skip bits.
   logic [7:0] port_two_crossbar_skip; // Port two skip bits.
   logic [7:0] port_three_crossbar_skip; // Port three skip bits.
   logic [7:0] p3_present; // Bonded port three pins.
   logic [7:0] p4_present; // Bonded port four pins.
   logic [7:0] p2_sampled; // Synchronised port two pins.
   logic [7:0] p3_sampled; // Synchronised port three pins.
   logic [7:0] p4_sampled; // Synchronised port four pins.
   logic [7:0] p2_view; // Port two pins as software reads them.
   logic [7:0] p3_view; // Port three pins as software reads them.
   logic [7:0] p4_view; // Port four pins as software reads them.
   logic [7:0] next_rdata; // Read data before the output flop.
   logic next_hit; // Decode result before the output flop.
   logic next_bit; // Bit read value before the output flop.
   logic large_pkg_s1; // Strap synchroniser, first stage.
   logic large_pkg; // Strap synchroniser, second stage.

   // Byte write decode shared by every register.
   function automatic logic wr_hit(input logic we, input logic [7:0] a,
                                   input logic [7:0] target);
      return we && (a == target);
   endfunction

   // Merge a single-bit write into a latch when the bit address matches.
   function automatic logic [7:0] bit_merge(input logic [7:0] cur,
         input logic we, input logic [7:0] ba, input logic [4:0] base,
         input logic d);
      logic [7:0] res;
      res = cur;
      if (we && (ba[7:3] == base)) begin
         res[ba[2:0]] = d;
      end
      return res;
   endfunction

   // Package strap passes two flops before it is used.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         large_pkg_s1 <= 1'b0;
         large_pkg <= 1'b0;
      end else begin
         large_pkg_s1 <= large_pkg_in;
         large_pkg <= large_pkg_s1;
      end
   end

   // Pin presence per package: on the small package port three has one pin, port four none.
   assign p3_present = large_pkg ? port_cfg_pkg::PINS_ALL
                                 : port_cfg_pkg::PINS_P3_SMALL;
   assign p4_present = large_pkg ? port_cfg_pkg::PINS_ALL
                                 : port_cfg_pkg::PINS_NONE;

   // Output latches, byte or bit written (port four byte only); reset high.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         port_two_pin_latch <= port_cfg_pkg::RST_LATCH;
         port_three_pin_latch <= port_cfg_pkg::RST_LATCH;
         port_four_pin_latch <= port_cfg_pkg::RST_LATCH;
      end else begin
         if (wr_hit(sfr_wr_in, sfr_addr_in, port_cfg_pkg::ADDR_P2_LATCH)) begin
            port_two_pin_latch <= sfr_wdata_in;
         end else begin
            port_two_pin_latch <= bit_merge(port_two_pin_latch, bit_wr_in,
               bit_addr_in, port_cfg_pkg::BIT_BASE_P2,
               bit_wdata_in);
         end
         if (wr_hit(sfr_wr_in, sfr_addr_in, port_cfg_pkg::ADDR_P3_LATCH)) begin
            port_three_pin_latch <= sfr_wdata_in;
         end else begin
            port_three_pin_latch <= bit_merge(port_three_pin_latch,
               bit_wr_in, bit_addr_in, port_cfg_pkg::BIT_BASE_P3,
               bit_wdata_in);
         end
         if (wr_hit(sfr_wr_in, sfr_addr_in, port_cfg_pkg::ADDR_P4_LATCH)) begin
            port_four_pin_latch <= sfr_wdata_in;
         end
      end
   end

   // Input mode registers; reset to digital.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         port_two_input_mode <= port_cfg_pkg::RST_IN_MODE;
         port_three_input_mode <= port_cfg_pkg::RST_IN_MODE;
         port_four_input_mode <= port_cfg_pkg::RST_IN_MODE;
      end else begin
         if (wr_hit(sfr_wr_in, sfr_addr_in,
                    port_cfg_pkg::ADDR_P2_IN_MODE)) begin
            port_two_input_mode <= sfr_wdata_in;
         end
         if (wr_hit(sfr_wr_in, sfr_addr_in,
                    port_cfg_pkg::ADDR_P3_IN_MODE)) begin
            port_three_input_mode <= sfr_wdata_in;
         end
         if (wr_hit(sfr_wr_in, sfr_addr_in,
                    port_cfg_pkg::ADDR_P4_IN_MODE)) begin
            port_four_input_mode <= sfr_wdata_in;
         end
      end
   end

   // Output mode registers; reset to open-drain.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         port_two_output_mode <= port_cfg_pkg::RST_OUT_MODE;
         port_three_output_mode <= port_cfg_pkg::RST_OUT_MODE;
         port_four_output_mode <= port_cfg_pkg::RST_OUT_MODE;
      end else begin
         if (wr_hit(sfr_wr_in, sfr_addr_in,
                    port_cfg_pkg::ADDR_P2_OUT_MODE)) begin
            port_two_output_mode <= sfr_wdata_in;
         end
         if (wr_hit(sfr_wr_in, sfr_addr_in,
                    port_cfg_pkg::ADDR_P3_OUT_MODE)) begin
            port_three_output_mode <= sfr_wdata_in;
         end
         if (wr_hit(sfr_wr_in, sfr_addr_in,
                    port_cfg_pkg::ADDR_P4_OUT_MODE)) begin
            port_four_output_mode <= sfr_wdata_in;
         end
      end
   end

   // Skip registers; reset to not skipped.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         port_one_crossbar_skip <= port_cfg_pkg::RST_SKIP;
         port_two_crossbar_skip <= port_cfg_pkg::RST_SKIP;
         port_three_crossbar_skip <= port_cfg_pkg::RST_SKIP;
      end else begin
         if (wr_hit(sfr_wr_in, sfr_addr_in, port_cfg_pkg::ADDR_P1_SKIP)) begin
            port_one_crossbar_skip <= sfr_wdata_in;
         end
         if (wr_hit(sfr_wr_in, sfr_addr_in, port_cfg_pkg::ADDR_P2_SKIP)) begin
            port_two_crossbar_skip <= sfr_wdata_in;
         end
         if (wr_hit(sfr_wr_in, sfr_addr_in, port_cfg_pkg::ADDR_P3_SKIP)) begin
            port_three_crossbar_skip <= sfr_wdata_in;
         end
      end
   end

   // Skip selections go to the crossbar from flops.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         p1_skip_out <= port_cfg_pkg::RST_SKIP;
         p2_skip_out <= port_cfg_pkg::RST_SKIP;
         p3_skip_out <= port_cfg_pkg::RST_SKIP;
      end else begin
         p1_skip_out <= port_one_crossbar_skip;
         p2_skip_out <= port_two_crossbar_skip;
         p3_skip_out <= port_three_crossbar_skip;
      end
   end

   // Pad logic for ports two to four; port one has no pad here.
   port_pin_pad pad_two (
      .clk_in(clk_in), .rst_b_in(rst_b_in),
      .latch_in(port_two_pin_latch), .in_mode_in(port_two_input_mode),
      .out_mode_in(port_two_output_mode),
      .present_in(port_cfg_pkg::PINS_ALL), .pin_in(p2_pin_in),
      .pin_out(p2_pin_out), .pin_oe_out(p2_pin_oe_out),
      .pullup_en_out(p2_pullup_out), .sampled_out(p2_sampled)
   );
   port_pin_pad pad_three (
      .clk_in(clk_in), .rst_b_in(rst_b_in),
      .latch_in(port_three_pin_latch),
      .in_mode_in(port_three_input_mode),
      .out_mode_in(port_three_output_mode), .present_in(p3_present),
      .pin_in(p3_pin_in), .pin_out(p3_pin_out),
      .pin_oe_out(p3_pin_oe_out), .pullup_en_out(p3_pullup_out),
      .sampled_out(p3_sampled)
   );
   port_pin_pad pad_four (
      .clk_in(clk_in), .rst_b_in(rst_b_in),
      .latch_in(port_four_pin_latch),
      .in_mode_in(port_four_input_mode),
      .out_mode_in(port_four_output_mode), .present_in(p4_present),
      .pin_in(p4_pin_in), .pin_out(p4_pin_out),
      .pin_oe_out(p4_pin_oe_out), .pullup_en_out(p4_pullup_out),
      .sampled_out(p4_sampled)
   );

   // Receivers of analog or absent pins are off and read as zero.
   assign p2_view = p2_sampled & port_two_input_mode;
   assign p3_view = p3_sampled & port_three_input_mode & p3_present;
   assign p4_view = p4_sampled & port_four_input_mode & p4_present;

   // Read mux: latches return pin levels, receivers off for analog.
   always_comb begin
      next_rdata = port_cfg_pkg::READ_NONE;
      next_hit = 1'b1;
      case (sfr_addr_in)
         port_cfg_pkg::ADDR_P2_LATCH: next_rdata = p2_view;
         port_cfg_pkg::ADDR_P3_LATCH: next_rdata = p3_view;
         port_cfg_pkg::ADDR_P4_LATCH: next_rdata = p4_view;
         port_cfg_pkg::ADDR_P2_IN_MODE: next_rdata = port_two_input_mode;
         port_cfg_pkg::ADDR_P3_IN_MODE: next_rdata = port_three_input_mode;
         port_cfg_pkg::ADDR_P4_IN_MODE: next_rdata = port_four_input_mode;
         port_cfg_pkg::ADDR_P2_OUT_MODE: next_rdata = port_two_output_mode;
         port_cfg_pkg::ADDR_P3_OUT_MODE: next_rdata = port_three_output_mode;
         port_cfg_pkg::ADDR_P4_OUT_MODE: next_rdata = port_four_output_mode;
         port_cfg_pkg::ADDR_P1_SKIP: next_rdata = port_one_crossbar_skip;
         port_cfg_pkg::ADDR_P2_SKIP: next_rdata = port_two_crossbar_skip;
         port_cfg_pkg::ADDR_P3_SKIP: next_rdata = port_three_crossbar_skip;
         default: next_hit = 1'b0;
      endcase
   end

   // Bit read picks one sampled pin of port two or three.
   always_comb begin
      next_bit = 1'b0;
      if (bit_addr_in[7:3] == port_cfg_pkg::BIT_BASE_P2) begin
         next_bit = p2_view[bit_addr_in[2:0]];
      end else if (bit_addr_in[7:3] == port_cfg_pkg::BIT_BASE_P3) begin
         next_bit = p3_view[bit_addr_in[2:0]];
      end
   end

   // Read answers appear one cycle after the strobe and then hold.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         sfr_rdata_out <= port_cfg_pkg::READ_NONE;
         sfr_hit_out <= 1'b0;
         bit_rdata_out <= 1'b0;
      end else begin
         if (sfr_rd_in) begin
            sfr_rdata_out <= next_rdata;
            sfr_hit_out <= next_hit;
         end
         if (bit_rd_in) begin
            bit_rdata_out <= next_bit;
         end
      end
   end

   // A byte write of zero to a digital port two latch bit drives low.
   property p_drive_low;
      @(posedge clk_in) disable iff (!rst_b_in)
      (sfr_wr_in && sfr_addr_in == port_cfg_pkg::ADDR_P2_LATCH
       && !sfr_wdata_in[0] && port_two_input_mode[0]
       && !(bit_wr_in)) |=> ##1 (p2_pin_oe_out[0] && !p2_pin_out[0]);
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("latch zero did not drive pin low");

   // An open-drain one is released; push-pull one drives high.
   property p_drive_high;
      @(posedge clk_in) disable iff (!rst_b_in)
      (port_two_pin_latch[1] && port_two_input_mode[1])
      |=> (p2_pin_oe_out[1] == $past(port_two_output_mode[1]));
   endproperty
   a_drive_high: assert property (p_drive_high)
      else $error("latch one drive type wrong");

   // Analog pins are neither driven nor pulled up.
   property p_analog_off;
      @(posedge clk_in) disable iff (!rst_b_in)
      !port_two_input_mode[2] |=> (!p2_pin_oe_out[2] && !p2_pullup_out[2]);
   endproperty
   a_analog_off: assert property (p_analog_off)
      else $error("analog pin still has digital circuitry on");

   // Latch read returns the pin level seen three cycles before.
   property p_read_pin;
      @(posedge clk_in) disable iff (!rst_b_in)
      (sfr_rd_in && sfr_addr_in == port_cfg_pkg::ADDR_P2_LATCH
       && port_two_input_mode == port_cfg_pkg::RST_IN_MODE
       && $stable(p2_pin_in) && $past(p2_pin_in) == $past(p2_pin_in, 2))
      |=> (sfr_rdata_out == $past(p2_pin_in));
   endproperty
   a_read_pin: assert property (p_read_pin)
      else $error("latch read did not return pin level");

   // Skip write reaches the crossbar output two edges later.
   property p_skip;
      @(posedge clk_in) disable iff (!rst_b_in)
      (sfr_wr_in && sfr_addr_in == port_cfg_pkg::ADDR_P2_SKIP)
      |=> ##1 (p2_skip_out == $past(sfr_wdata_in, 2));
   endproperty
   a_skip: assert property (p_skip)
      else $error("skip write did not reach crossbar");

   // Absent pins of port three are never driven on the small package.
   property p_p3_small;
      @(posedge clk_in) disable iff (!rst_b_in)
      !large_pkg |=> (p3_pin_oe_out[7:1] == 7'h00);
   endproperty
   a_p3_small: assert property (p_p3_small)
      else $error("absent port three pin driven");

   // Port four is silent on the small package.
   property p_p4_small;
      @(posedge clk_in) disable iff (!rst_b_in)
      !large_pkg |=> (p4_pin_oe_out == 8'h00 && p4_pullup_out == 8'h00);
   endproperty
   a_p4_small: assert property (p_p4_small)
      else $error("port four active on small package");

   // A bit write sets the addressed port three latch bit to the written value.
   property p_bit_write;
      @(posedge clk_in) disable iff (!rst_b_in)
      (bit_wr_in && bit_addr_in[7:3] == port_cfg_pkg::BIT_BASE_P3
       && !(sfr_wr_in && sfr_addr_in == port_cfg_pkg::ADDR_P3_LATCH))
      |=> (port_three_pin_latch[$past(bit_addr_in[2:0])]
           == $past(bit_wdata_in));
   endproperty
   a_bit_write: assert property (p_bit_write)
      else $error("bit write lost");

   // After reset every pin of port two is released and pulled up.
   property p_reset_state;
      @(posedge clk_in)
      !rst_b_in ##1 rst_b_in |=> (p2_pin_oe_out == 8'h00
                                  && p2_pullup_out == 8'hFF);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("pins not digital open-drain high after reset");
endmodule // port_pin_config_regs

// ==== hdl/port_pin_pad.sv ====
/*
 Pad control and input sampling for one 8-pin port. Works out drive
 enables from latch, mode bits and pin presence, and syncs pin levels.
 Assumes pins come from outside the clock domain.
*/
`timescale 1ns/1ps
module port_pin_pad (
   input wire logic clk_in, // System clock.
   input wire logic rst_b_in, // Synchronous reset, active low.
   input wire logic [7:0] latch_in, // Output latch.
   input wire logic [7:0] in_mode_in, // One means digital.
   input wire logic [7:0] out_mode_in, // One means push-pull.
   input wire logic [7:0] present_in, // Bonded pins.
   input wire logic [7:0] pin_in, // Raw pin levels.
   output logic [7:0] pin_out, // Level driven when enabled.
   output logic [7:0] pin_oe_out, // High while driving the pin.
   output logic [7:0] pullup_en_out, // Weak pull-up enable.
   output logic [7:0] sampled_out // Synchronised pin levels.
);
   logic [7:0] sync_first; // First synchroniser stage only.
   logic [7:0] digital; // Pin is present and digital.

   assign digital = in_mode_in & present_in;

   // Drive low on zero; drive high only when push-pull, else release.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         pin_out <= 8'h00;
         pin_oe_out <= 8'h00;
         pullup_en_out <= 8'h00;
      end else begin
         pin_out <= latch_in & digital;
         pin_oe_out <= digital
                       & (~latch_in | out_mode_in);
         pullup_en_out <= digital;
      end
   end

   // Two-stage sync of every pin; analog or absent pins are not masked here.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         sync_first <= 8'h00;
         sampled_out <= 8'h00;
      end else begin
         sync_first <= pin_in;
         sampled_out <= sync_first;
      end
   end
endmodule // port_pin_pad

// ==== sim/pin_partner.sv ====
/* Far-side model of one 8-pin port wire bundle.
   Assumes the bench drives the outside driver enable and level. */
`timescale 1ns/1ps
module pin_partner (
   input wire logic clk_in, // Bench clock.
   input wire logic [7:0] pin_in, // Device drive level.
   input wire logic [7:0] oe_in, // Device drive enable.
   input wire logic [7:0] pullup_in, // Weak pull-up enable.
   input wire logic [7:0] ext_en_in, // Outside driver enable.
   input wire logic [7:0] ext_val_in, // Outside driver level.
   output logic [7:0] wire_out // Resolved wire level.
);
   logic [7:0] drift = 8'h55; // Undriven level, never stale.
   // Flip the undriven pattern every cycle.
   always_ff @(posedge clk_in) begin
      drift <= ~drift;
   end
   // Device drive wins, then the outside driver, then the pull-up.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         wire_out[i] = oe_in[i] ? pin_in[i] : ext_en_in[i] ?
            ext_val_in[i] : pullup_in[i] ? 1'b1 : drift[i];
      end
   end
endmodule // pin_partner

// ==== sim/port_pin_config_regs_tb_top.sv ====
/* Self-checking bench for the port registers.
   Assumes one partner per port and a 200 MHz clock. */
`timescale 1ns/1ps
module port_pin_config_regs_tb_top;
   logic clk_in = 0, rst_b_in = 0, large_pkg_in = 1; // Clock, strap.
   logic sfr_wr_in = 0, sfr_rd_in = 0, bit_wr_in = 0, bit_rd_in = 0;
   logic [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, bit_addr_in = 0;
   logic bit_wdata_in = 0, bit_rdata_out, sfr_hit_out, rd_seen = 0;
   logic [7:0] p2_pin_in, p3_pin_in, p4_pin_in, sfr_rdata_out;
   logic [7:0] p2_pin_out, p2_pin_oe_out, p2_pullup_out, p1_skip_out;
   logic [7:0] p3_pin_out, p3_pin_oe_out, p3_pullup_out, p2_skip_out;
   logic [7:0] p4_pin_out, p4_pin_oe_out, p4_pullup_out, p3_skip_out;
   logic [7:0] ext_en = 0, ext_val = 0, r, v [9], ca [9];
   logic [8:0] exp_q [$]; // Expected hit and data of each read.
   logic [31:0] seed = 32'hAADCA71C;
   int err_total = 0, n_checks = 0, cycles = 0;
   port_pin_config_regs uut (.clk_in, .rst_b_in, .large_pkg_in,
      .sfr_wr_in, .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in, .bit_wr_in,
      .bit_rd_in, .bit_addr_in, .bit_wdata_in, .p2_pin_in, .p3_pin_in,
      .p4_pin_in, .sfr_rdata_out, .sfr_hit_out, .bit_rdata_out,
      .p2_pin_out, .p2_pin_oe_out, .p2_pullup_out, .p3_pin_out,
      .p3_pin_oe_out, .p3_pullup_out, .p4_pin_out, .p4_pin_oe_out,
      .p4_pullup_out, .p1_skip_out, .p2_skip_out, .p3_skip_out);
   pin_partner w2 (.clk_in, .pin_in(p2_pin_out), .oe_in(p2_pin_oe_out),
      .pullup_in(p2_pullup_out), .ext_en_in(ext_en),
      .ext_val_in(ext_val), .wire_out(p2_pin_in));
   pin_partner w3 (.clk_in, .pin_in(p3_pin_out), .oe_in(p3_pin_oe_out),
      .pullup_in(p3_pullup_out), .ext_en_in(8'h00),
      .ext_val_in(8'h00), .wire_out(p3_pin_in));
   pin_partner w4 (.clk_in, .pin_in(p4_pin_out), .oe_in(p4_pin_oe_out),
      .pullup_in(p4_pullup_out), .ext_en_in(8'h00),
      .ext_val_in(8'h00), .wire_out(p4_pin_in));
   // Clock of 5 ns period.
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   // Fixed-seed xorshift source of random bytes.
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // Count a compare and report a mismatch.
   task automatic chk(input logic [8:0] s, input logic [8:0] e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("wrong value at %0t: %h vs %h", $time, s, e);
      end
   endtask
   // Print counts and verdict, then stop.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Byte access; a read notes its expected hit and data.
   task automatic acc(input logic w, input logic [7:0] a, d,
                      input logic h = 1'b1);
      if (!w) exp_q.push_back({h, d});
      @(posedge clk_in);
      #1 sfr_wr_in = w;
      sfr_rd_in = ~w;
      sfr_addr_in = a;
      sfr_wdata_in = d;
      @(posedge clk_in);
      #1 sfr_wr_in = 1'b0;
      sfr_rd_in = 1'b0;
   endtask
   // Single-bit access; a read is compared at once.
   task automatic bt(input logic w, input logic [4:0] b,
                     input logic [2:0] i, input logic d);
      @(posedge clk_in);
      #1 bit_wr_in = w;
      bit_rd_in = ~w;
      bit_addr_in = {b, i};
      bit_wdata_in = d;
      @(posedge clk_in);
      #1 bit_wr_in = 1'b0;
      bit_rd_in = 1'b0;
      if (!w) chk(bit_rdata_out, d);
   endtask
   // Let the pad and the pin syncs settle.
   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Read data stands one cycle after the strobe edge.
   always @(posedge clk_in) begin
      if (rd_seen) begin
         chk({sfr_hit_out, sfr_rdata_out}, exp_q.pop_front());
      end
      rd_seen <= sfr_rd_in;
   end
   // Cut a hang short.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         end_sim();
      end
   end
   // Main sequence.
   initial begin
      ca = '{8'hA6, 8'hA7, 8'hAE, 8'hD5, 8'hD6, 8'hDF, 8'hF3, 8'hF4, 8'hF5};
      idle(2);
      rst_b_in = 1'b1;
      idle(4);
      chk(p2_pin_oe_out, 8'h00); // Released high.
      chk(p2_pullup_out, 8'hFF);
      acc(0, 8'hA0, 8'hFF); // Pulled-up pins read high.
      for (int i = 0; i < 9; i++) begin
         acc(0, ca[i], i < 6 ? 8'h00 : 8'hFF);
         v[i] = xs();
         acc(1, ca[i], v[i]);
         acc(0, ca[i], v[i]); // Read back.
      end
      chk(p1_skip_out, v[3]);
      chk(p2_skip_out, v[4]);
      chk(p3_skip_out, v[5]);
      for (int i = 0; i < 9; i++) acc(1, ca[i], i < 6 ? 8'h00 : 8'hFF);
      r = xs();
      acc(1, 8'hA0, r);
      idle(3);
      chk(p2_pin_oe_out, 8'(~r)); // Zero drives, one floats.
      acc(0, 8'hA0, r); // Level at the pins.
      acc(1, 8'hA6, 8'hFF);
      idle(1);
      chk(p2_pin_oe_out, 8'hFF); // Push-pull drives.
      chk(p2_pin_out, r);
      acc(1, 8'hF3, 8'h0F);
      idle(3);
      chk(p2_pin_oe_out, 8'h0F); // Analog pins undriven.
      chk(p2_pullup_out & 8'hF0, 8'h00);
      acc(0, 8'hA0, r & 8'h0F); // Receiver off.
      acc(1, 8'hF3, 8'hFF);
      acc(1, 8'hA6, 8'h00);
      acc(1, 8'hA0, 8'hFF);
      ext_val = xs();
      ext_en = 8'hFF;
      idle(4);
      acc(0, 8'hA0, ext_val); // Input levels read.
      bt(0, 5'h14, 3'd2, ext_val[2]);
      ext_en = 8'h00;
      bt(1, 5'h14, 3'd7, 1'b0);
      bt(1, 5'h16, 3'd5, 1'b0);
      idle(3);
      chk(p3_pin_oe_out, 8'h20);
      chk(p3_pin_out, 8'hDF);
      acc(0, 8'hA0, 8'h7F);
      acc(0, 8'hB0, 8'hDF); // Eight pins on large.
      bt(0, 5'h16, 3'd4, 1'b1);
      acc(0, 8'h00, 8'h00, 1'b0); // Unmapped address.
      chk(p4_pullup_out, 8'hFF); // Port four alive on large.
      large_pkg_in = 1'b0;
      idle(5);
      chk(p4_pin_oe_out | p4_pullup_out, 8'h00);
      chk(p4_pin_out, 8'h00);
      chk(p3_pullup_out, 8'h01);
      acc(0, 8'hC7, 8'h00); // No pins on small.
      acc(0, 8'hB0, 8'h01); // Only bit zero.
      idle(3);
      end_sim();
   end
endmodule // port_pin_config_regs_tb_top
